// >>> tb/image_sensor_output_control_regs_tb.sv
// self-checking bench for the sensor output control register bank
`timescale 1ns/1ps
`default_nettype none
module image_sensor_output_control_regs_tb;
	// clock, reset and event inputs
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic frame_start = 1'b0;
	logic mode_change = 1'b0;
	logic exposure_step = 1'b0;
	logic band_filter_en = 1'b0;
	// inputs at rest, except line_active, y_in and uv_in, which are driven late in the run
	logic line_start = 1'b0;
	logic line_active = 1'b0;
	logic field_odd = 1'b0;
	logic [7:0] y_in = 8'h00;
	logic signed [7:0] uv_in = 8'sh00;
	// design outputs
	isoc_pkg::isoc_reg_req_t reg_req;
	isoc_pkg::isoc_ctrl_t ctrl;
	logic [7:0] reg_rdata, y_o, uv_o, d;
	logic [8:0] hsync_start, hsync_end;
	logic pclk_o, line_valid_pin_o, hsync_pin_o, field_pin_o, ctrl_pins_oe, video_oe;
	logic soft_power_down, timing_reset, image_settled, frame_dropped;
	// register table: address, reset value, writable bits
	logic [7:0] ad [10] = '{8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h4D, 8'h4E};
	logic [7:0] rv [10] = '{8'h81, 8'h00, 8'h0F, 8'h3C, 8'h21, 8'h08, 8'h80, 8'h02, 8'h02, 8'hA0};
	logic [7:0] mk [10] = '{8'hDA, 8'h5F, 8'hFF, 8'hFF, 8'h1F, 8'h8A, 8'h94, 8'h53, 8'h18, 8'hE0};
	int fail_count = 0;
	int checks_done = 0;
	// 40 MHz clock
	always begin
		#12.5 ref_clk = ~ref_clk;
	end
	isoc_host host (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
	isoc_regs #(.SLOW_SETTLE_FRAMES(4)) uut (.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .line_start(line_start), .line_active(line_active),
		.frame_start(frame_start), .field_odd(field_odd), .mode_change(mode_change),
		.exposure_step(exposure_step), .band_filter_en(band_filter_en), .y_in(y_in),
		.uv_in(uv_in), .pclk_o(pclk_o), .line_valid_pin_o(line_valid_pin_o),
		.hsync_pin_o(hsync_pin_o), .field_pin_o(field_pin_o), .ctrl_pins_oe(ctrl_pins_oe),
		.y_o(y_o), .uv_o(uv_o), .video_oe(video_oe), .ctrl(ctrl), .hsync_start(hsync_start),
		.hsync_end(hsync_end), .soft_power_down(soft_power_down),
		.timing_reset(timing_reset), .image_settled(image_settled),
		.frame_dropped(frame_dropped));
	// value comparison
	task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// reset held two cycles
	task automatic do_reset();
		@(posedge ref_clk);
		#2 rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#2 rst = 1'b0;
	endtask
	// count pixel clock rises over sixteen cycles
	task automatic rises(input logic [8:0] e);
		int n;
		logic p;
		n = 0;
		@(posedge ref_clk);
		#2 p = pclk_o;
		repeat (16) begin
			@(posedge ref_clk);
			#2 if (pclk_o === 1'b1 && p === 1'b0) n++;
			p = pclk_o;
		end
		chk("pixel clock rises", e, n[8:0]);
	endtask
	// timing reset aligns the first tick, then two ticks of video are checked
	task automatic video(input logic [7:0] m, input logic [8:0] y0, input logic [8:0] u0,
		input logic [8:0] y1, input logic [8:0] u1);
		host.wr(8'h3E, m);
		host.wr(8'h3F, 8'h03);
		repeat (2) @(posedge ref_clk);
		#2 chk("luma first", y0, {1'b0, y_o});
		chk("chroma first", u0, {1'b0, uv_o});
		repeat (2) @(posedge ref_clk);
		#2 chk("luma second", y1, {1'b0, y_o});
		chk("chroma second", u1, {1'b0, uv_o});
	endtask
	// verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// watchdog well beyond the expected run
	initial begin
		#(25 * 3000);
		fail_count++;
		results();
	end
	// test sequence
	initial begin
		repeat (2) @(posedge ref_clk);
		#2 rst = 1'b0;
		for (int i = 0; i < 10; i++) begin
			host.rd(ad[i], d);
			chk("reset value", {1'b0, rv[i]}, {1'b0, d});
		end
		host.rd(8'h50, d);
		chk("unmapped read", 9'h000, {1'b0, d});
		// all ones into every register but the power and timing one
		for (int i = 0; i < 10; i++) begin
			if (i != 7) begin
				host.wr(ad[i], 8'hFF);
				host.rd(ad[i], d);
				chk("masked write", {1'b0, mk[i] | (i == 0 ? 8'h81 : 8'h00)}, {1'b0, d});
			end
		end
		chk("control pins enable", 9'h000, {8'h00, ctrl_pins_oe});
		chk("min exposure", 9'h004, {6'h00, ctrl.min_exp_lines});
		chk("exposure speed", 9'h01F, {4'h0, ctrl.exp_speed});
		chk("reference level", 9'h007, {6'h00, ctrl.ref_level});
		chk("frame drop enable", 9'h001, {8'h00, ctrl.frame_drop_en});
		chk("quarter settle", 9'h001, {8'h00, ctrl.awb_quarter});
		chk("sync start", 9'h1FF, hsync_start);
		chk("sync end", 9'h1FF, hsync_end);
		do_reset();
		chk("min exposure", 9'h001, {6'h00, ctrl.min_exp_lines});
		chk("reference level", 9'h005, {6'h00, ctrl.ref_level});
		chk("embedded code format", 9'h001, {8'h00, ctrl.itu656_en});
		chk("fifty hertz timing", 9'h001, {8'h00, ctrl.pal_en});
		host.window(9'h110, 9'h120);
		chk("sync start", 9'h110, hsync_start);
		chk("sync end", 9'h120, hsync_end);
		rises(9'h008);
		host.wr(8'h3E, 8'h00);
		rises(9'h004);
		host.wr(8'h3F, 8'h03);
		chk("timing reset", 9'h001, {8'h00, timing_reset});
		@(posedge ref_clk);
		#2 chk("timing reset", 9'h000, {8'h00, timing_reset});
		host.rd(8'h3F, d);
		chk("timing reset self clear", 9'h002, {1'b0, d});
		host.wr(8'h3F, 8'h42);
		@(posedge ref_clk);
		#2 chk("clock on field pin high", 9'h001, {8'h00, field_pin_o});
		#13 chk("clock on field pin low", 9'h000, {8'h00, field_pin_o});
		host.wr(8'h3D, 8'h0A);
		host.wr(8'h3F, 8'h12);
		chk("soft power down", 9'h001, {8'h00, soft_power_down});
		chk("video enable", 9'h000, {8'h00, video_oe});
		host.wr(8'h3F, 8'h02);
		chk("soft power down", 9'h000, {8'h00, soft_power_down});
		chk("video enable", 9'h001, {8'h00, video_oe});
		host.wr(8'h38, 8'h08);
		@(posedge ref_clk);
		#2 mode_change = 1'b1;
		@(posedge ref_clk);
		#2 mode_change = 1'b0;
		chk("settled after change", 9'h000, {8'h00, image_settled});
		frame_start = 1'b1;
		@(posedge ref_clk);
		#2 frame_start = 1'b0;
		repeat (2) @(posedge ref_clk);
		#2 chk("settled first frame", 9'h001, {8'h00, image_settled});
		host.wr(8'h3D, 8'h80);
		band_filter_en = 1'b1;
		exposure_step = 1'b1;
		@(posedge ref_clk);
		#2 exposure_step = 1'b0;
		frame_start = 1'b1;
		@(posedge ref_clk);
		#2 frame_start = 1'b0;
		@(posedge ref_clk);
		#2 chk("frame dropped", 9'h001, {8'h00, frame_dropped});
		host.wr(8'h4D, 8'h18);
		y_in = 8'h5A;
		uv_in = 8'sh40;
		video(8'h80, 9'h05A, 9'h020, 9'h05A, 9'h038);
		video(8'h90, 9'h005, 9'h002, 9'h00A, 9'h000);
		host.wr(8'h39, 8'h40);
		rises(9'h000);
		line_active = 1'b1;
		rises(9'h008);
		results();
	end
endmodule
`default_nettype wire

// >>> tb/isoc_host.sv
// host model that drives the register port of the sensor control bank
`timescale 1ns/1ps
`default_nettype none
module isoc_host (
	// clock
	input wire logic ref_clk,
	// register port
	output var isoc_pkg::isoc_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata
);
	// idle port at time zero
	initial begin
		reg_req = '0;
	end
	// one write, strobe taken at a single edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#2 reg_req = '{wr: 1'b1, addr: a, wdata: d};
		@(posedge ref_clk);
		#2 reg_req.wr = 1'b0;
		reg_req.wdata = ~d;
	endtask
	// read data settles within the cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		#2 reg_req.addr = a;
		#10 d = reg_rdata;
	endtask
	// sync window, only ever programmed with end after start
	task automatic window(input logic [8:0] s, input logic [8:0] e);
		if (e > s) begin
			wr(8'h39, {6'h00, s[8], e[8]});
			wr(8'h3A, s[7:0]);
			wr(8'h3B, e[7:0]);
		end
	endtask
endmodule
`default_nettype wire

// >>> verilog/isoc_pclk_gen.sv
// pixel clock divider with line-valid gating
`timescale 1ns/1ps
`default_nettype none
module isoc_pclk_gen (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// controls
	input wire logic div2,
	input wire logic gate_en,
	input wire logic line_active,
	input wire logic hold,
	// outputs
	output logic pclk_ff,
	output logic tick
);
	logic [1:0] cnt_ff; // divider phase
	logic raw_ff; // ungated divided clock

	// divide by two or four, held during timing reset
	always_ff @(posedge ref_clk) begin
		if (rst || hold) begin
			cnt_ff <= 2'h0;
			raw_ff <= 1'b0;
		end else if (div2 || cnt_ff[0]) begin
			cnt_ff <= 2'h0;
			raw_ff <= ~raw_ff;
		end else begin
			cnt_ff <= cnt_ff + 2'h1;
		end
	end
	// one tick per rising edge of the divided clock
	assign tick = ~raw_ff && (div2 || cnt_ff[0]) && !hold;

	// gated copy, low outside active lines when gating is on
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pclk_ff <= 1'b0;
		end else begin
			pclk_ff <= (gate_en && !line_active) ? 1'b0 : raw_ff;
		end
	end
endmodule
`default_nettype wire

// >>> verilog/isoc_pin_mux.sv
// output pin function swap and tristate enables
`timescale 1ns/1ps
`default_nettype none
module isoc_pin_mux (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// selects
	input wire logic hs_on_lv,
	input wire logic lv_on_hs,
	input wire logic ctrl_tri,
	input wire logic clk_on_fld,
	// internal timing signals
	input wire logic line_valid,
	input wire logic hsync,
	input wire logic field_odd,
	// pins
	output logic lv_pin_o,
	output logic hs_pin_o,
	output logic fld_pin_o,
	output logic ctrl_oe
);
	logic fld_ff; // registered field indicator

	// swap sync functions between the two pins
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lv_pin_o <= 1'b0;
			hs_pin_o <= 1'b0;
			fld_ff <= 1'b0;
		end else begin
			lv_pin_o <= hs_on_lv ? hsync : line_valid;
			hs_pin_o <= lv_on_hs ? line_valid : hsync;
			fld_ff <= field_odd;
		end
	end
	// main clock goes straight out when selected
	assign fld_pin_o = clk_on_fld ? ref_clk : fld_ff;
	// control pins float when tristate is set
	assign ctrl_oe = !ctrl_tri;
endmodule
`default_nettype wire

// >>> verilog/isoc_pkg.sv
// shared constants and types for the sensor output control register bank
package isoc_pkg;
	// register addresses on the serial control port
	localparam logic [7:0] ADDR_STABILITY = 8'h38;
	localparam logic [7:0] ADDR_OUT_PINS = 8'h39;
	localparam logic [7:0] ADDR_HS_START = 8'h3A;
	localparam logic [7:0] ADDR_HS_END = 8'h3B;
	localparam logic [7:0] ADDR_EXP_SPEED = 8'h3C;
	localparam logic [7:0] ADDR_DROP_PAL = 8'h3D;
	localparam logic [7:0] ADDR_CLK_NIBBLE = 8'h3E;
	localparam logic [7:0] ADDR_PWR_TIMING = 8'h3F;
	localparam logic [7:0] ADDR_CHROMA = 8'h4D;
	localparam logic [7:0] ADDR_REF_LEVEL = 8'h4E;
	// reset values
	localparam logic [7:0] RST_STABILITY = 8'h81;
	localparam logic [7:0] RST_OUT_PINS = 8'h00;
	localparam logic [7:0] RST_HS_START = 8'h0F;
	localparam logic [7:0] RST_HS_END = 8'h3C;
	localparam logic [7:0] RST_EXP_SPEED = 8'h21;
	localparam logic [7:0] RST_DROP_PAL = 8'h08;
	localparam logic [7:0] RST_CLK_NIBBLE = 8'h80;
	localparam logic [7:0] RST_PWR_TIMING = 8'h02;
	localparam logic [7:0] RST_CHROMA = 8'h02;
	localparam logic [7:0] RST_REF_LEVEL = 8'hA0;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	// writable bit masks, writes clear reserved bits except in stability, which keeps its reset bits
	localparam logic [7:0] MASK_STABILITY = 8'hDA;
	localparam logic [7:0] MASK_OUT_PINS = 8'h5F;
	localparam logic [7:0] MASK_EXP_SPEED = 8'h1F;
	localparam logic [7:0] MASK_DROP_PAL = 8'h8A;
	localparam logic [7:0] MASK_CLK_NIBBLE = 8'h94;
	localparam logic [7:0] MASK_PWR_TIMING = 8'h53;
	localparam logic [7:0] MASK_CHROMA = 8'h18;
	localparam logic [7:0] MASK_REF_LEVEL = 8'hE0;
	// field positions
	localparam int B_QUICK = 3;
	localparam int B_AWB_QTR = 1;
	localparam int B_PCLK_GATE = 6;
	localparam int B_HS_ON_LV = 4;
	localparam int B_LV_ON_HS = 3;
	localparam int B_CTRL_TRI = 2;
	localparam int B_HS_START8 = 1;
	localparam int B_HS_END8 = 0;
	localparam int B_FRAME_DROP = 7;
	localparam int B_PAL = 3;
	localparam int B_VID_TRI_PD = 1;
	localparam int B_DIV2 = 7;
	localparam int B_NIBBLE = 4;
	localparam int B_MIN_EXP4 = 2;
	localparam int B_CLK_ON_FLD = 6;
	localparam int B_SOFT_PD = 4;
	localparam int B_ITU656 = 1;
	localparam int B_TIM_RST = 0;
	localparam int B_CHROMA_LO = 3;
	localparam int B_REF_LO = 5;
	// minimum exposure in lines
	localparam logic [2:0] MIN_EXP_LONG = 3'h4;
	localparam logic [2:0] MIN_EXP_SHORT = 3'h1;
	// chroma gains in 1/256 units
	localparam logic signed [9:0] GAIN_UNITY = 10'sh100;
	localparam logic signed [9:0] GAIN_U1 = 10'sh0F0;
	localparam logic signed [9:0] GAIN_V1 = 10'sh0D6;
	localparam logic signed [9:0] GAIN_U2 = 10'sh090;
	localparam logic signed [9:0] GAIN_V2 = 10'sh0B7;
	localparam logic signed [9:0] GAIN_U3 = 10'sh080;
	localparam logic signed [9:0] GAIN_V3 = 10'sh0E0;
	localparam int GAIN_SHIFT = 8;
	// register access from the serial control port decoder
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} isoc_reg_req_t;
	// decoded controls for exposure, gain and timing logic
	typedef struct packed {
		logic [4:0] exp_speed;
		logic [2:0] ref_level;
		logic [2:0] min_exp_lines;
		logic frame_drop_en;
		logic pal_en;
		logic itu656_en;
		logic quick_stable;
		logic awb_quarter;
	} isoc_ctrl_t;
	// settling state, one-hot
	typedef enum logic [1:0] {
		ST_STABLE = 2'b01,
		ST_SETTLE = 2'b10
	} isoc_settle_t;
endpackage

// >>> verilog/isoc_regs.sv
// sensor output control register bank and the logic it steers
// What this block does
// - quick mode: first frame after change settled
// - gated pixel clock only while line active, not stopped in dropped frames
// - composite sync may drive line valid pin
// - line valid may drive composite sync pin
// - tristate bit floats all control outputs
// - sync start is nine bits wide
// - sync end is nine bits wide
// - speed bits pick exposure adaptation rate
// - drop one frame on exposure change with band filter on
// - PAL bit selects 50 Hz timing
// - video ports float during power down
// - main clock divided by two or four
// - nibble mode sends four bits per tick
// - minimum exposure four lines or one
// - main clock may drive field pin
// - soft power down bit sleeps, clears wakes
// - control bit selects embedded-code video format
// - timing reset keeps exposure, gain, balance
// - two-bit field scales chroma outputs
// - three-bit exposure reference level
`timescale 1ns/1ps
`default_nettype none
module isoc_regs #(
	parameter int SLOW_SETTLE_FRAMES = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register access from the serial control decoder
	input wire isoc_pkg::isoc_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	// timing and exposure core events
	input wire logic line_start,
	input wire logic line_active,
	input wire logic frame_start,
	input wire logic field_odd,
	input wire logic mode_change,
	input wire logic exposure_step,
	input wire logic band_filter_en,
	// video from the processing chain
	input wire logic [7:0] y_in,
	input wire logic signed [7:0] uv_in,
	// control pins
	output logic pclk_o,
	output logic line_valid_pin_o,
	output logic hsync_pin_o,
	output logic field_pin_o,
	output logic ctrl_pins_oe,
	// video pins
	output logic [7:0] y_o,
	output logic [7:0] uv_o,
	output logic video_oe,
	// decoded controls
	output isoc_pkg::isoc_ctrl_t ctrl,
	output logic [8:0] hsync_start,
	output logic [8:0] hsync_end,
	output logic soft_power_down,
	output logic timing_reset,
	output logic image_settled,
	output logic frame_dropped
);
	// register storage
	logic [7:0] stab_ff; // stability control
	logic [7:0] pins_ff; // output pin control
	logic [7:0] hs_start_ff; // sync start low bits
	logic [7:0] hs_end_ff; // sync end low bits
	logic [7:0] speed_ff; // exposure change speed
	logic [7:0] drop_ff; // frame drop and PAL
	logic [7:0] clkn_ff; // clock divide and nibble
	logic [7:0] pwr_ff; // power and timing
	logic [7:0] chroma_ff; // chroma matrix
	logic [7:0] ref_ff; // exposure reference
	// datapath state
	logic [8:0] hcount_ff; // pixel ticks since line start
	logic hsync_ff; // internal sync window
	logic uv_is_v_ff; // chroma phase within the line
	logic nib_lo_ff; // nibble phase
	logic [7:0] y_hold_ff; // luma held for nibble pairs
	logic [7:0] uv_hold_ff; // chroma held for nibble pairs
	logic drop_pend_ff; // exposure changed, drop next frame
	logic drop_ff_act; // current frame is being dropped
	logic [7:0] settle_cnt_ff; // frames left to settle
	isoc_pkg::isoc_settle_t settle_ff; // settling state
	isoc_pkg::isoc_settle_t nxt_settle;
	logic [7:0] nxt_settle_cnt;
	logic signed [9:0] gain; // chroma gain for this pixel
	logic signed [17:0] uv_prod; // scaled chroma product
	logic [7:0] uv_scaled; // scaled chroma byte
	logic tick; // pixel tick
	logic wr_pwr; // write to power and timing register

	// register writes, reserved bits kept at zero, or at their reset value in stability
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stab_ff <= isoc_pkg::RST_STABILITY;
			pins_ff <= isoc_pkg::RST_OUT_PINS;
			hs_start_ff <= isoc_pkg::RST_HS_START;
			hs_end_ff <= isoc_pkg::RST_HS_END;
			speed_ff <= isoc_pkg::RST_EXP_SPEED;
			drop_ff <= isoc_pkg::RST_DROP_PAL;
			clkn_ff <= isoc_pkg::RST_CLK_NIBBLE;
			chroma_ff <= isoc_pkg::RST_CHROMA;
			ref_ff <= isoc_pkg::RST_REF_LEVEL;
		end else if (reg_req.wr) begin
			if (reg_req.addr == isoc_pkg::ADDR_STABILITY) begin
				stab_ff <= (reg_req.wdata & isoc_pkg::MASK_STABILITY)
					| (isoc_pkg::RST_STABILITY & ~isoc_pkg::MASK_STABILITY);
			end else if (reg_req.addr == isoc_pkg::ADDR_OUT_PINS) begin
				pins_ff <= reg_req.wdata & isoc_pkg::MASK_OUT_PINS;
			end else if (reg_req.addr == isoc_pkg::ADDR_HS_START) begin
				hs_start_ff <= reg_req.wdata;
			end else if (reg_req.addr == isoc_pkg::ADDR_HS_END) begin
				hs_end_ff <= reg_req.wdata;
			end else if (reg_req.addr == isoc_pkg::ADDR_EXP_SPEED) begin
				speed_ff <= reg_req.wdata & isoc_pkg::MASK_EXP_SPEED;
			end else if (reg_req.addr == isoc_pkg::ADDR_DROP_PAL) begin
				drop_ff <= reg_req.wdata & isoc_pkg::MASK_DROP_PAL;
			end else if (reg_req.addr == isoc_pkg::ADDR_CLK_NIBBLE) begin
				clkn_ff <= reg_req.wdata & isoc_pkg::MASK_CLK_NIBBLE;
			end else if (reg_req.addr == isoc_pkg::ADDR_CHROMA) begin
				chroma_ff <= reg_req.wdata & isoc_pkg::MASK_CHROMA;
			end else if (reg_req.addr == isoc_pkg::ADDR_REF_LEVEL) begin
				ref_ff <= reg_req.wdata & isoc_pkg::MASK_REF_LEVEL;
			end
		end
	end

	assign wr_pwr = reg_req.wr && (reg_req.addr == isoc_pkg::ADDR_PWR_TIMING);

	// power register, timing reset bit clears itself after one cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pwr_ff <= isoc_pkg::RST_PWR_TIMING;
		end else if (wr_pwr) begin
			pwr_ff <= reg_req.wdata & isoc_pkg::MASK_PWR_TIMING;
		end else begin
			pwr_ff[isoc_pkg::B_TIM_RST] <= 1'b0;
		end
	end

	// read mux, unmapped addresses return zero
	always_comb begin
		if (reg_req.addr == isoc_pkg::ADDR_STABILITY) begin
			reg_rdata = stab_ff;
		end else if (reg_req.addr == isoc_pkg::ADDR_OUT_PINS) begin
			reg_rdata = pins_ff;
		end else if (reg_req.addr == isoc_pkg::ADDR_HS_START) begin
			reg_rdata = hs_start_ff;
		end else if (reg_req.addr == isoc_pkg::ADDR_HS_END) begin
			reg_rdata = hs_end_ff;
		end else if (reg_req.addr == isoc_pkg::ADDR_EXP_SPEED) begin
			reg_rdata = speed_ff;
		end else if (reg_req.addr == isoc_pkg::ADDR_DROP_PAL) begin
			reg_rdata = drop_ff;
		end else if (reg_req.addr == isoc_pkg::ADDR_CLK_NIBBLE) begin
			reg_rdata = clkn_ff;
		end else if (reg_req.addr == isoc_pkg::ADDR_PWR_TIMING) begin
			reg_rdata = pwr_ff;
		end else if (reg_req.addr == isoc_pkg::ADDR_CHROMA) begin
			reg_rdata = chroma_ff;
		end else if (reg_req.addr == isoc_pkg::ADDR_REF_LEVEL) begin
			reg_rdata = ref_ff;
		end else begin
			reg_rdata = isoc_pkg::READ_UNMAPPED;
		end
	end

	// decoded controls for the exposure and timing cores
	assign ctrl.exp_speed = speed_ff[4:0];
	assign ctrl.ref_level = ref_ff[isoc_pkg::B_REF_LO +: 3];
	assign ctrl.min_exp_lines = clkn_ff[isoc_pkg::B_MIN_EXP4] ? isoc_pkg::MIN_EXP_LONG
		: isoc_pkg::MIN_EXP_SHORT;
	assign ctrl.frame_drop_en = drop_ff[isoc_pkg::B_FRAME_DROP];
	assign ctrl.pal_en = drop_ff[isoc_pkg::B_PAL];
	assign ctrl.itu656_en = pwr_ff[isoc_pkg::B_ITU656];
	assign ctrl.quick_stable = stab_ff[isoc_pkg::B_QUICK];
	assign ctrl.awb_quarter = stab_ff[isoc_pkg::B_AWB_QTR];
	assign hsync_start = {pins_ff[isoc_pkg::B_HS_START8], hs_start_ff};
	assign hsync_end = {pins_ff[isoc_pkg::B_HS_END8], hs_end_ff};
	assign soft_power_down = pwr_ff[isoc_pkg::B_SOFT_PD];
	assign timing_reset = pwr_ff[isoc_pkg::B_TIM_RST];

	// pixel clock source
	isoc_pclk_gen u_pclk (
		.ref_clk(ref_clk),
		.rst(rst),
		.div2(clkn_ff[isoc_pkg::B_DIV2]),
		.gate_en(pins_ff[isoc_pkg::B_PCLK_GATE]),
		.line_active(line_active),
		.hold(timing_reset || soft_power_down),
		.pclk_ff(pclk_o),
		.tick(tick)
	);

	// horizontal position and sync window, cleared by reset, timing reset or line start
	always_ff @(posedge ref_clk) begin
		if (rst || timing_reset || line_start) begin
			hcount_ff <= 9'h000;
			hsync_ff <= 1'b0;
		end else if (tick) begin
			hcount_ff <= hcount_ff + 9'h001;
			// host keeps end above start, else the window stays shut
			hsync_ff <= (hcount_ff >= hsync_start) && (hcount_ff < hsync_end);
		end
	end

	// sync and field pin routing
	isoc_pin_mux u_pins (
		.ref_clk(ref_clk),
		.rst(rst),
		.hs_on_lv(pins_ff[isoc_pkg::B_HS_ON_LV]),
		.lv_on_hs(pins_ff[isoc_pkg::B_LV_ON_HS]),
		.ctrl_tri(pins_ff[isoc_pkg::B_CTRL_TRI]),
		.clk_on_fld(pwr_ff[isoc_pkg::B_CLK_ON_FLD]),
		.line_valid(line_active && !drop_ff_act),
		.hsync(hsync_ff),
		.field_odd(field_odd),
		.lv_pin_o(line_valid_pin_o),
		.hs_pin_o(hsync_pin_o),
		.fld_pin_o(field_pin_o),
		.ctrl_oe(ctrl_pins_oe)
	);

	// chroma gain from matrix select and chroma phase
	always_comb begin
		case (chroma_ff[isoc_pkg::B_CHROMA_LO +: 2])
			2'h1: gain = uv_is_v_ff ? isoc_pkg::GAIN_V1 : isoc_pkg::GAIN_U1;
			2'h2: gain = uv_is_v_ff ? isoc_pkg::GAIN_V2 : isoc_pkg::GAIN_U2;
			2'h3: gain = uv_is_v_ff ? isoc_pkg::GAIN_V3 : isoc_pkg::GAIN_U3;
			default: gain = isoc_pkg::GAIN_UNITY;
		endcase
	end
	assign uv_prod = uv_in * gain;
	assign uv_scaled = uv_prod[isoc_pkg::GAIN_SHIFT +: 8];

	// video output, byte wide or nibble pairs
	always_ff @(posedge ref_clk) begin
		if (rst || timing_reset || line_start) begin
			uv_is_v_ff <= 1'b0;
			nib_lo_ff <= 1'b0;
			y_hold_ff <= 8'h00;
			uv_hold_ff <= 8'h00;
			y_o <= 8'h00;
			uv_o <= 8'h00;
		end else if (tick) begin
			if (clkn_ff[isoc_pkg::B_NIBBLE]) begin
				// high nibble first, low nibble on the next tick
				nib_lo_ff <= ~nib_lo_ff;
				if (!nib_lo_ff) begin
					y_hold_ff <= y_in;
					uv_hold_ff <= uv_scaled;
					uv_is_v_ff <= ~uv_is_v_ff;
					y_o <= {4'h0, y_in[7:4]};
					uv_o <= {4'h0, uv_scaled[7:4]};
				end else begin
					y_o <= {4'h0, y_hold_ff[3:0]};
					uv_o <= {4'h0, uv_hold_ff[3:0]};
				end
			end else begin
				uv_is_v_ff <= ~uv_is_v_ff;
				y_o <= y_in;
				uv_o <= uv_scaled;
			end
		end
	end
	// video pins float in power down when asked
	assign video_oe = !(soft_power_down && drop_ff[isoc_pkg::B_VID_TRI_PD]);

	// frame drop on exposure change, an event wins over the frame-start clear
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			drop_pend_ff <= 1'b0;
			drop_ff_act <= 1'b0;
		end else begin
			if (frame_start) begin
				drop_ff_act <= drop_pend_ff;
			end
			if (exposure_step && ctrl.frame_drop_en && band_filter_en) begin
				drop_pend_ff <= 1'b1;
			end else if (frame_start) begin
				drop_pend_ff <= 1'b0;
			end
		end
	end
	assign frame_dropped = drop_ff_act;

	// settling after a camera mode change
	always_comb begin
		nxt_settle = settle_ff;
		nxt_settle_cnt = settle_cnt_ff;
		case (settle_ff)
			isoc_pkg::ST_STABLE: begin
				if (mode_change) begin
					nxt_settle = isoc_pkg::ST_SETTLE;
					if (ctrl.quick_stable) begin
						nxt_settle_cnt = 8'h01;
					end else if (ctrl.awb_quarter) begin
						nxt_settle_cnt = 8'(SLOW_SETTLE_FRAMES / 4);
					end else begin
						nxt_settle_cnt = 8'(SLOW_SETTLE_FRAMES);
					end
				end
			end
			isoc_pkg::ST_SETTLE: begin
				if (frame_start) begin
					nxt_settle_cnt = settle_cnt_ff - 8'h01;
					if (settle_cnt_ff <= 8'h01) begin
						nxt_settle = isoc_pkg::ST_STABLE;
					end
				end
			end
			default: nxt_settle = isoc_pkg::ST_STABLE;
		endcase
	end

	// settling state registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			settle_ff <= isoc_pkg::ST_STABLE;
			settle_cnt_ff <= 8'h00;
		end else begin
			settle_ff <= nxt_settle;
			settle_cnt_ff <= nxt_settle_cnt;
		end
	end
	assign image_settled = (settle_ff == isoc_pkg::ST_STABLE);

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	AST_QUICK_ONE_FRAME: assert property (
		(settle_ff == isoc_pkg::ST_STABLE) && mode_change && ctrl.quick_stable ##1 frame_start
		|=> image_settled)
		else $error("quick mode not settled after first frame");
	AST_PCLK_GATED: assert property (
		$past(pins_ff[isoc_pkg::B_PCLK_GATE]) && !$past(line_active) |-> !pclk_o)
		else $error("gated pixel clock ran outside line");
	AST_LV_PIN: assert property (
		pins_ff[isoc_pkg::B_HS_ON_LV] && $stable(pins_ff) |=> line_valid_pin_o == $past(hsync_ff))
		else $error("line valid pin wrong source");
	AST_HS_PIN: assert property (
		!pins_ff[isoc_pkg::B_LV_ON_HS] && $stable(pins_ff) |=> hsync_pin_o == $past(hsync_ff))
		else $error("sync pin wrong source");
	AST_CTRL_TRI: assert property (
		pins_ff[isoc_pkg::B_CTRL_TRI] |-> !ctrl_pins_oe)
		else $error("control pins driven while tristated");
	AST_HS_WINDOW: assert property (
		tick && !line_start && !timing_reset && (hcount_ff == hsync_start)
		&& (hsync_end > hsync_start) |=> hsync_ff)
		else $error("sync did not open at start position");
	AST_HS_END: assert property (
		tick && !line_start && !timing_reset && (hcount_ff == hsync_end) |=> !hsync_ff)
		else $error("sync open at end position");
	AST_DROP: assert property (
		exposure_step && ctrl.frame_drop_en && band_filter_en ##1 frame_start
		|=> frame_dropped)
		else $error("frame not dropped after exposure change");
	AST_VID_TRI: assert property (
		soft_power_down && drop_ff[isoc_pkg::B_VID_TRI_PD] |-> !video_oe)
		else $error("video driven in power down");
	AST_TIM_RST_PULSE: assert property (
		timing_reset |=> !timing_reset || $past(wr_pwr))
		else $error("timing reset stuck");
	AST_MIN_EXP: assert property (
		clkn_ff[isoc_pkg::B_MIN_EXP4] |-> ctrl.min_exp_lines == isoc_pkg::MIN_EXP_LONG)
		else $error("minimum exposure wrong");

	COV_MODE_CHANGE: cover property (mode_change ##[1:50] image_settled);
	COV_DROP: cover property (frame_dropped);
	COV_NIBBLE: cover property (clkn_ff[isoc_pkg::B_NIBBLE] && tick ##1 nib_lo_ff);
endmodule
`default_nettype wire
